// ===== pkg/ldcr_pkg.sv
// Purpose: Constants for the display control register set
// Assumes: Direct register access over an 8-bit host port with 16-bit addresses
// Notes: Rates derive from the frame pulse supplied by the panel timing logic
package ldcr_pkg;
    localparam int LDCR_AW = 16;
    localparam int LDCR_DW = 8;
    localparam logic [15:0] LDCR_DISP_ON_ADDR = 16'h8009;
    localparam logic [15:0] LDCR_ATTR_ADDR = 16'h800A;
    localparam logic [15:0] LDCR_B1_LO_ADDR = 16'h800B;
    localparam logic [15:0] LDCR_B1_HI_ADDR = 16'h800C;
    localparam logic [15:0] LDCR_B1_LINES_ADDR = 16'h800D;
    localparam logic [15:0] LDCR_B2_LO_ADDR = 16'h800E;
    localparam logic [15:0] LDCR_B2_HI_ADDR = 16'h800F;
    localparam logic [15:0] LDCR_B2_LINES_ADDR = 16'h8010;
    localparam logic [15:0] LDCR_B3_LO_ADDR = 16'h8011;
    localparam logic [15:0] LDCR_B3_HI_ADDR = 16'h8012;
    localparam logic [15:0] LDCR_B4_LO_ADDR = 16'h8013;
    localparam logic [15:0] LDCR_B4_HI_ADDR = 16'h8014;
    localparam logic [7:0] LDCR_RESET_VAL = 8'h00;
    // Field positions inside the attribute register, and the enable bit of the display on register
    localparam int LDCR_CURSOR_LSB = 0;
    localparam int LDCR_BLK1_LSB = 2;
    localparam int LDCR_BLK2_LSB = 4;
    localparam int LDCR_BLK3_LSB = 6;
    localparam int LDCR_ENABLE_BIT = 0;
    // Attribute encodings
    localparam logic [1:0] LDCR_ATTR_OFF = 2'h0;
    localparam logic [1:0] LDCR_ATTR_STEADY = 2'h1;
    localparam logic [1:0] LDCR_ATTR_SLOW = 2'h2;
    localparam logic [1:0] LDCR_ATTR_FAST = 2'h3;
    // Frame counter taps: divide by 4, 32, 64
    localparam int LDCR_FRAME_CNT_W = 6;
    localparam int LDCR_TAP_DIV4 = 1;
    localparam int LDCR_TAP_DIV32 = 4;
    localparam int LDCR_TAP_DIV64 = 5;
    // Cursor visible 70 percent of the blink period
    localparam int LDCR_DUTY_ON_PCT = 70;
    localparam int LDCR_PCT_FULL = 100;
endpackage

// ===== design/ldcr_blink_gen.sv
// Purpose: Free-running frame counter with flash and blink phase outputs
// Assumes: frame_tick is a one-cycle pulse per panel frame
// Notes: Cursor blink phases are decoded from the counter for 70/30 duty
`timescale 1ns/1ps
module ldcr_blink_gen
    import ldcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_tick,
    output logic flash_fast,
    output logic flash_slow,
    output logic cursor_slow,
    output logic cursor_very_slow
);
    typedef struct packed {
        logic [LDCR_FRAME_CNT_W-1:0] cnt;
        logic fast;
        logic slow;
        logic cur_slow;
        logic cur_vslow;
    } ldcr_blink_s;

    ldcr_blink_s state_reg;
    ldcr_blink_s state_next;

    // Blink periods in frames, taken from the counter taps so they follow them
    localparam int SLOW_PERIOD = 2 ** (LDCR_TAP_DIV32 + 1);
    localparam int VSLOW_PERIOD = 2 ** (LDCR_TAP_DIV64 + 1);

    // Visible while the phase is under 70 percent of the period
    function automatic logic duty_on(input logic [LDCR_FRAME_CNT_W-1:0] phase, input int period);
        duty_on = (int'(phase) * LDCR_PCT_FULL) < (period * LDCR_DUTY_ON_PCT);
    endfunction

    // Counter and registered phases; flashes are 50 percent squares
    always_comb begin
        state_next = state_reg;
        if (frame_tick) begin
            state_next.cnt = state_reg.cnt + 1'b1;
        end
        state_next.fast = state_next.cnt[LDCR_TAP_DIV4];
        state_next.slow = state_next.cnt[LDCR_TAP_DIV32];
        state_next.cur_slow = duty_on({1'b0, state_next.cnt[LDCR_TAP_DIV32:0]}, SLOW_PERIOD);
        state_next.cur_vslow = duty_on(state_next.cnt, VSLOW_PERIOD);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flash_fast = state_reg.fast;
    assign flash_slow = state_reg.slow;
    assign cursor_slow = state_reg.cur_slow;
    assign cursor_very_slow = state_reg.cur_vslow;
endmodule

// ===== design/ldcr_origin_latch.sv
// Purpose: One screen block start address with low/high staging
// Assumes: Host writes low byte first, then high byte
// Notes: The live address only moves on a high byte write
`timescale 1ns/1ps
module ldcr_origin_latch
    import ldcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [LDCR_DW-1:0] wr_data,
    output logic [LDCR_DW-1:0] low_shadow,
    output logic [2*LDCR_DW-1:0] origin
);
    typedef struct packed {
        logic [LDCR_DW-1:0] low;
        logic [2*LDCR_DW-1:0] live;
    } ldcr_origin_s;

    ldcr_origin_s state_reg;
    ldcr_origin_s state_next;

    // Low byte only stages; a high byte write commits both halves together
    always_comb begin
        state_next = state_reg;
        if (wr_low) begin
            state_next.low = wr_data;
        end
        if (wr_high) begin
            state_next.live = {wr_data, state_reg.low};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign low_shadow = state_reg.low;
    assign origin = state_reg.live;
endmodule

// ===== design/ldcr_display_ctrl.sv
// Purpose: Display control register bank of a graphic LCD controller
// Assumes: Direct host port with chip select, write and read strobes per cycle
// Notes: Frame pulse, memory access pulses and power save come from neighbours
//
// Overview of operation
// - Enable bit 0 off blanks whole display and cursor, overriding attributes.
// - Bits 7-6 set third block: blank, steady, flash frame/32, frame/4.
// - Bits 5-4 set second block, also fourth block in dual panel.
// - Bits 3-2 set first block with same blank/steady/flash encoding.
// - Bits 1-0 set cursor: hidden, steady, blink frame/32, frame/64.
// - Blinking cursor visible seventy percent, hidden thirty percent.
// - Memory write re-enables disabled cursor and advances cursor position.
// - Memory read advances cursor but leaves disabled cursor disabled.
// - Old start address stays until high byte written, then all changes.
// - Each block start address is sixteen bits from low/high pair.
// - First block size register holds line count minus one.
// - Second block size register holds line count minus one.
// - Entering power save clears the display enable bit.
`timescale 1ns/1ps
module ldcr_display_ctrl
    import ldcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [LDCR_AW-1:0] host_addr,
    input wire logic [LDCR_DW-1:0] host_wdata,
    output logic [LDCR_DW-1:0] host_rdata,
    input wire logic frame_tick,
    input wire logic dual_panel,
    input wire logic power_save_enter,
    input wire logic mem_write,
    input wire logic mem_read,
    input wire logic [LDCR_AW-1:0] cursor_step,
    input wire logic cursor_load,
    input wire logic [LDCR_AW-1:0] cursor_load_value,
    output logic display_enabled,
    output logic block1_visible,
    output logic block2_visible,
    output logic block3_visible,
    output logic block4_visible,
    output logic cursor_visible,
    output logic [LDCR_AW-1:0] cursor_addr,
    output logic [LDCR_AW-1:0] first_block_origin,
    output logic [LDCR_AW-1:0] second_block_origin,
    output logic [LDCR_AW-1:0] third_block_origin,
    output logic [LDCR_AW-1:0] fourth_block_origin,
    output logic [LDCR_DW-1:0] first_block_lines,
    output logic [LDCR_DW-1:0] second_block_lines
);
    localparam int NUM_BLOCKS = 4;

    typedef struct packed {
        logic enable;
        logic [LDCR_DW-1:0] attr;
        logic [LDCR_DW-1:0] lines1;
        logic [LDCR_DW-1:0] lines2;
        logic cursor_forced;
        logic [LDCR_AW-1:0] cursor;
        logic [LDCR_DW-1:0] rdata;
        logic [NUM_BLOCKS-1:0] blk_vis;
        logic cur_vis;
    } ldcr_ctrl_s;

    ldcr_ctrl_s state_reg;
    ldcr_ctrl_s state_next;

    logic flash_fast;
    logic flash_slow;
    logic cursor_slow;
    logic cursor_very_slow;
    logic [NUM_BLOCKS-1:0] wr_low;
    logic [NUM_BLOCKS-1:0] wr_high;
    logic [LDCR_DW-1:0] low_shadow [NUM_BLOCKS];
    logic [LDCR_AW-1:0] origin [NUM_BLOCKS];
    logic host_write;
    logic host_read;

    // Low and high byte addresses of each block origin
    localparam logic [15:0] LO_ADDR [NUM_BLOCKS] = '{LDCR_B1_LO_ADDR, LDCR_B2_LO_ADDR,
                                                    LDCR_B3_LO_ADDR, LDCR_B4_LO_ADDR};
    localparam logic [15:0] HI_ADDR [NUM_BLOCKS] = '{LDCR_B1_HI_ADDR, LDCR_B2_HI_ADDR,
                                                    LDCR_B3_HI_ADDR, LDCR_B4_HI_ADDR};

    assign host_write = host_cs && host_wr;
    assign host_read = host_cs && host_rd;

    // Block flash decode, shared by all four blocks
    function automatic logic block_on(input logic [1:0] attr, input logic fast, input logic slow);
        unique case (attr)
            LDCR_ATTR_OFF: block_on = 1'b0;
            LDCR_ATTR_STEADY: block_on = 1'b1;
            LDCR_ATTR_SLOW: block_on = slow;
            LDCR_ATTR_FAST: block_on = fast;
        endcase
    endfunction

    ldcr_blink_gen u_blink (
        .ref_clk(ref_clk),
        .reset(reset),
        .frame_tick(frame_tick),
        .flash_fast(flash_fast),
        .flash_slow(flash_slow),
        .cursor_slow(cursor_slow),
        .cursor_very_slow(cursor_very_slow)
    );

    // One staging latch per block origin
    genvar g;
    generate
        for (g = 0; g < NUM_BLOCKS; g++) begin : g_origin
            assign wr_low[g] = host_write && (host_addr == LO_ADDR[g]);
            assign wr_high[g] = host_write && (host_addr == HI_ADDR[g]);
            ldcr_origin_latch u_origin (
                .ref_clk(ref_clk),
                .reset(reset),
                .wr_low(wr_low[g]),
                .wr_high(wr_high[g]),
                .wr_data(host_wdata),
                .low_shadow(low_shadow[g]),
                .origin(origin[g])
            );
        end
    endgenerate

    // Register writes, cursor motion, read mux and visibility
    always_comb begin
        logic [1:0] cur_attr;
        cur_attr = 2'h0;
        state_next = state_reg;
        if (host_write) begin
            unique case (host_addr)
                LDCR_DISP_ON_ADDR: state_next.enable = host_wdata[LDCR_ENABLE_BIT];
                LDCR_ATTR_ADDR: begin
                    state_next.attr = host_wdata;
                    state_next.cursor_forced = 1'b0;
                end
                LDCR_B1_LINES_ADDR: state_next.lines1 = host_wdata;
                LDCR_B2_LINES_ADDR: state_next.lines2 = host_wdata;
                default: ;
            endcase
        end
        // Power save wins over a simultaneous enable write
        if (power_save_enter) begin
            state_next.enable = 1'b0;
        end
        // Cursor address: direct load, otherwise step on every memory access
        if (cursor_load) begin
            state_next.cursor = cursor_load_value;
        end else if (mem_write || mem_read) begin
            state_next.cursor = state_reg.cursor + cursor_step;
        end
        // Only a write revives a hidden cursor; a read leaves it alone
        if (mem_write && state_reg.attr[LDCR_CURSOR_LSB +: 2] == LDCR_ATTR_OFF) begin
            state_next.cursor_forced = 1'b1;
        end
        // Read data, unmapped addresses read as zero
        state_next.rdata = LDCR_RESET_VAL;
        if (host_read) begin
            unique case (host_addr)
                LDCR_DISP_ON_ADDR: state_next.rdata = {7'h00, state_reg.enable};
                LDCR_ATTR_ADDR: state_next.rdata = state_reg.attr;
                LDCR_B1_LINES_ADDR: state_next.rdata = state_reg.lines1;
                LDCR_B2_LINES_ADDR: state_next.rdata = state_reg.lines2;
                LDCR_B1_LO_ADDR: state_next.rdata = low_shadow[0];
                LDCR_B1_HI_ADDR: state_next.rdata = origin[0][LDCR_AW-1:LDCR_DW];
                LDCR_B2_LO_ADDR: state_next.rdata = low_shadow[1];
                LDCR_B2_HI_ADDR: state_next.rdata = origin[1][LDCR_AW-1:LDCR_DW];
                LDCR_B3_LO_ADDR: state_next.rdata = low_shadow[2];
                LDCR_B3_HI_ADDR: state_next.rdata = origin[2][LDCR_AW-1:LDCR_DW];
                LDCR_B4_LO_ADDR: state_next.rdata = low_shadow[3];
                LDCR_B4_HI_ADDR: state_next.rdata = origin[3][LDCR_AW-1:LDCR_DW];
                default: state_next.rdata = LDCR_RESET_VAL;
            endcase
        end
        // Block visibility, all gated by the master enable
        state_next.blk_vis[0] = state_reg.enable &&
            block_on(state_reg.attr[LDCR_BLK1_LSB +: 2], flash_fast, flash_slow);
        state_next.blk_vis[1] = state_reg.enable &&
            block_on(state_reg.attr[LDCR_BLK2_LSB +: 2], flash_fast, flash_slow);
        state_next.blk_vis[2] = state_reg.enable &&
            block_on(state_reg.attr[LDCR_BLK3_LSB +: 2], flash_fast, flash_slow);
        // Fourth block has no field of its own; it follows the second
        state_next.blk_vis[3] = state_reg.enable && dual_panel &&
            block_on(state_reg.attr[LDCR_BLK2_LSB +: 2], flash_fast, flash_slow);
        // A revived cursor shows steadily until the attribute is rewritten
        cur_attr = state_reg.attr[LDCR_CURSOR_LSB +: 2];
        if (state_reg.cursor_forced && cur_attr == LDCR_ATTR_OFF) begin
            cur_attr = LDCR_ATTR_STEADY;
        end
        unique case (cur_attr)
            LDCR_ATTR_OFF: state_next.cur_vis = 1'b0;
            LDCR_ATTR_STEADY: state_next.cur_vis = state_reg.enable;
            LDCR_ATTR_SLOW: state_next.cur_vis = state_reg.enable && cursor_slow;
            LDCR_ATTR_FAST: state_next.cur_vis = state_reg.enable && cursor_very_slow;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered outputs
    assign host_rdata = state_reg.rdata;
    assign display_enabled = state_reg.enable;
    assign block1_visible = state_reg.blk_vis[0];
    assign block2_visible = state_reg.blk_vis[1];
    assign block3_visible = state_reg.blk_vis[2];
    assign block4_visible = state_reg.blk_vis[3];
    assign cursor_visible = state_reg.cur_vis;
    assign cursor_addr = state_reg.cursor;
    assign first_block_origin = origin[0];
    assign second_block_origin = origin[1];
    assign third_block_origin = origin[2];
    assign fourth_block_origin = origin[3];
    assign first_block_lines = state_reg.lines1;
    assign second_block_lines = state_reg.lines2;
endmodule

// ===== tb/ldcr_display_ctrl_chk.sv
// Purpose: Port assertions for the display control bank
// Assumes: One clock, synchronous active high reset
// Notes: Attribute byte is shadowed here from host writes
`timescale 1ns/1ps
module ldcr_display_ctrl_chk
    import ldcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic [LDCR_AW-1:0] host_addr,
    input wire logic [LDCR_DW-1:0] host_wdata,
    input wire logic power_save_enter,
    input wire logic mem_write,
    input wire logic display_enabled,
    input wire logic block1_visible,
    input wire logic cursor_visible,
    input wire logic [LDCR_AW-1:0] first_block_origin,
    input wire logic [LDCR_DW-1:0] first_block_lines
);
    logic [LDCR_DW-1:0] attr_reg;
    logic wr_en;
    // Write strobe as the bank takes it
    assign wr_en = host_cs && host_wr;
    // Shadow of the attribute byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            attr_reg <= LDCR_RESET_VAL;
        end else if (wr_en && host_addr == LDCR_ATTR_ADDR) begin
            attr_reg <= host_wdata;
        end
    end
    // Visibility lags the registers by one cycle
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    chk_off_blanks: assert property (!display_enabled
        |=> !block1_visible && !cursor_visible) else $error("shown while off");
    chk_enable_load: assert property (wr_en && host_addr == LDCR_DISP_ON_ADDR && !power_save_enter
        |=> display_enabled == $past(host_wdata[LDCR_ENABLE_BIT])) else $error("enable not loaded");
    chk_save_clears: assert property (power_save_enter |=> !display_enabled)
        else $error("enable kept");
    chk_origin_hold: assert property (!(wr_en && host_addr == LDCR_B1_HI_ADDR)
        |=> $stable(first_block_origin)) else $error("origin moved early");
    chk_origin_commit: assert property (wr_en && host_addr == LDCR_B1_HI_ADDR
        |=> first_block_origin[15:8] == $past(host_wdata)) else $error("origin high wrong");
    chk_lines_load: assert property (wr_en && host_addr == LDCR_B1_LINES_ADDR
        |=> first_block_lines == $past(host_wdata)) else $error("line count wrong");
    chk_block_steady: assert property (display_enabled && attr_reg[3:2] == LDCR_ATTR_STEADY
        |=> block1_visible) else $error("steady block hidden");
    chk_cursor_wake: assert property (mem_write && attr_reg[1:0] == LDCR_ATTR_OFF
        && !(wr_en && host_addr == LDCR_ATTR_ADDR) ##1 display_enabled |=> cursor_visible)
        else $error("cursor not woken");
endmodule
bind ldcr_display_ctrl ldcr_display_ctrl_chk u_ldcr_display_ctrl_chk (.ref_clk, .reset, .host_cs,
    .host_wr, .host_addr, .host_wdata, .power_save_enter, .mem_write, .display_enabled,
    .block1_visible, .cursor_visible, .first_block_origin, .first_block_lines);

// ===== tb/ldcr_host_model.sv
// Purpose: Host processor model for the register port
// Assumes: One strobe cycle per access, read data one cycle later
// Notes: Address and data lines idle at the inverse of the last value sent; strobes drop to zero
`timescale 1ns/1ps
module ldcr_host_model
    import ldcr_pkg::*;
(
    input wire logic ref_clk,
    output logic host_cs,
    output logic host_wr,
    output logic host_rd,
    output logic [LDCR_AW-1:0] host_addr,
    output logic [LDCR_DW-1:0] host_wdata,
    input wire logic [LDCR_DW-1:0] host_rdata
);
    // Bus idle from time zero
    initial begin
        {host_cs, host_wr, host_rd} = 3'h0;
        host_addr = 16'h0000;
        host_wdata = 8'h00;
    end
    // Strobe held over one edge, released right after it
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        {host_cs, host_wr, host_rd} <= {1'b1, wr, !wr};
        host_addr <= a;
        host_wdata <= d;
        @(posedge ref_clk);
        {host_cs, host_wr, host_rd} <= 3'h0;
        host_addr <= ~a;
        host_wdata <= ~d;
        #1;
        q = host_rdata;
    endtask
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the display control bank
// Assumes: Frame period of four clocks
// Notes: Flash counts span 64 frames, a whole very slow period
`timescale 1ns/1ps
module tb
    import ldcr_pkg::*;
;
    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] r;} ldcr_row_s;
    logic ref_clk, reset, host_cs, host_wr, host_rd, frame_tick, dual_panel, power_save_enter;
    logic mem_write, mem_read, cursor_load, display_enabled, cursor_visible;
    logic block1_visible, block2_visible, block3_visible, block4_visible;
    logic [4:0] shown;
    logic [LDCR_DW-1:0] host_wdata, host_rdata, rdv, first_block_lines, second_block_lines;
    logic [LDCR_AW-1:0] host_addr, cursor_addr, first_block_origin, second_block_origin;
    logic [LDCR_AW-1:0] third_block_origin, fourth_block_origin;
    logic [LDCR_AW-1:0] cursor_step = 16'h0003;
    logic [LDCR_AW-1:0] cursor_load_value = 16'h0100;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    // Address, byte written, byte read back
    ldcr_row_s rows [13] = '{'{16'h8009, 8'hFF, 8'h01}, '{16'h800A, 8'hE4, 8'hE4},
        '{16'h800B, 8'h11, 8'h11}, '{16'h800C, 8'h22, 8'h22}, '{16'h800D, 8'h33, 8'h33},
        '{16'h800E, 8'h44, 8'h44}, '{16'h800F, 8'h55, 8'h55}, '{16'h8010, 8'h66, 8'h66},
        '{16'h8011, 8'h77, 8'h77}, '{16'h8012, 8'h88, 8'h88}, '{16'h8013, 8'h99, 8'h99},
        '{16'h8014, 8'hAA, 8'hAA}, '{16'h8015, 8'h5A, 8'h00}};
    assign shown = {block4_visible, block3_visible, block2_visible, block1_visible, cursor_visible};
    ldcr_display_ctrl u_ldcr_display_ctrl (.ref_clk, .reset, .host_cs, .host_wr, .host_rd, .host_addr,
        .host_wdata, .host_rdata, .frame_tick, .dual_panel, .power_save_enter, .mem_write, .mem_read,
        .cursor_step, .cursor_load, .cursor_load_value, .display_enabled, .block1_visible,
        .block2_visible, .block3_visible, .block4_visible, .cursor_visible, .cursor_addr,
        .first_block_origin, .second_block_origin, .third_block_origin, .fourth_block_origin,
        .first_block_lines, .second_block_lines);
    ldcr_host_model u_ldcr_host_model (.ref_clk, .host_cs, .host_wr, .host_rd, .host_addr,
        .host_wdata, .host_rdata);
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Register access through the host model
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        u_ldcr_host_model.access(1'b1, a, d, rdv);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        u_ldcr_host_model.access(1'b0, a, 8'h00, rdv);
        check(rdv, e);
    endtask
    // One-cycle side pulse, then time for visibility to settle
    task automatic pulse(input logic [4:0] m);
        @(posedge ref_clk);
        {cursor_load, power_save_enter, mem_read, mem_write, frame_tick} <= m;
        @(posedge ref_clk);
        {cursor_load, power_save_enter, mem_read, mem_write, frame_tick} <= 5'h00;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    // Block toggles and cursor-on frames over 64 frames
    task automatic flash(input logic [7:0] at, input int e1, input int e2, input int e3, input int ec);
        int g1 = 0;
        int g2 = 0;
        int g3 = 0;
        int cc = 0;
        logic [4:0] p;
        wreg(LDCR_ATTR_ADDR, at);
        pulse(5'h00);
        p = shown;
        repeat (64) begin
            pulse(5'h01);
            g1 += int'(shown[1] != p[1]);
            g2 += int'(shown[2] != p[2]);
            g3 += int'(shown[3] != p[3]);
            cc += int'(cursor_visible);
            p = shown;
        end
        check(16'(g1), 16'(e1));
        check(16'(g2), 16'(e2));
        check(16'(g3), 16'(e3));
        check(16'(cc), 16'(ec));
    endtask
    // Single exit of the run
    task automatic print_verdict;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // 40 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Hang guard, run needs under 1000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Reset, table loop, then the awkward cases
    initial begin
        {cursor_load, power_save_enter, mem_read, mem_write, frame_tick} = 5'h00;
        dual_panel = 1'b1;
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            rchk(rows[i].a, 8'h00);
        end
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].r);
        end
        check(first_block_origin, 16'h2211);
        check(fourth_block_origin, 16'hAA99);
        check(second_block_origin, 16'h5544);
        check(first_block_lines, 8'h33);
        check(second_block_lines, 8'h66);
        // Low byte alone leaves the live origin
        wreg(LDCR_B3_LO_ADDR, 8'hCD);
        check(third_block_origin, 16'h8877);
        wreg(LDCR_B3_HI_ADDR, 8'hAB);
        check(third_block_origin, 16'hABCD);
        wreg(LDCR_ATTR_ADDR, 8'h55);
        pulse(5'h00);
        check(shown, 5'h1F);
        // Single panel: fourth block has nothing to follow
        @(posedge ref_clk);
        dual_panel <= 1'b0;
        pulse(5'h00);
        check(shown, 5'h0F);
        @(posedge ref_clk);
        dual_panel <= 1'b1;
        wreg(LDCR_DISP_ON_ADDR, 8'h00);
        pulse(5'h00);
        check(shown, 5'h00);
        wreg(LDCR_DISP_ON_ADDR, 8'h01);
        wreg(LDCR_ATTR_ADDR, 8'h00);
        pulse(5'h00);
        check(shown, 5'h00);
        // Cursor off: a read only moves it, a write also shows it
        pulse(5'h10);
        pulse(5'h04);
        check({cursor_visible, cursor_addr[14:0]}, 16'h0103);
        pulse(5'h02);
        check({cursor_visible, cursor_addr[14:0]}, 16'h8106);
        flash(8'hEE, 32, 4, 32, 46);
        flash(8'hBB, 4, 32, 4, 45);
        pulse(5'h08);
        check(display_enabled, 1'b0);
        rchk(LDCR_DISP_ON_ADDR, 8'h00);
        // Mid-run reset clears staged and live state alike
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check({shown, display_enabled, first_block_lines}, 16'h0000);
        check(third_block_origin, 16'h0000);
        rchk(LDCR_B3_LO_ADDR, 8'h00);
        print_verdict();
    end
endmodule
